// file: rtl/sft_pkg.sv
// Constants, types and register map of the skip-on-flag test unit.
package sft_pkg;

  // Register byte offsets
  localparam logic [31:0] SFT_OFS_PIN_CTRL   = 32'h0000_0000;
  localparam logic [31:0] SFT_OFS_IRQ_EN     = 32'h0000_0004;
  localparam logic [31:0] SFT_OFS_FLAGS      = 32'h0000_0008;
  localparam logic [31:0] SFT_OFS_INT_STATUS = 32'h0000_000C;
  localparam logic [31:0] SFT_OFS_INT_MASK   = 32'h0000_0010;

  // Field positions
  localparam int SFT_PIN_POL_BIT  = 2;
  localparam int SFT_T1_EN_BIT    = 2;
  localparam int SFT_T2_EN_BIT    = 3;
  localparam int SFT_EV_SKIP      = 0;
  localparam int SFT_EV_T1_SET    = 1;
  localparam int SFT_EV_T2_SET    = 2;
  localparam int SFT_EV_PIN_EDGE  = 3;

  // Values after reset
  localparam logic [3:0] SFT_PIN_CTRL_RST = 4'h0;
  localparam logic [3:0] SFT_IRQ_EN_RST   = 4'h0;
  localparam logic [3:0] SFT_STATUS_RST   = 4'h0;
  localparam logic [3:0] SFT_MASK_RST     = 4'h0;
  localparam logic [2:0] SFT_SYNC_RST     = 3'h0;
  localparam logic       SFT_PIN_RST      = 1'h0;
  localparam logic       SFT_FLAG_RST     = 1'h0;

  // Instruction selector seen from the core
  typedef enum logic [2:0] {
    SFT_OP_OTHER                  = 3'h0,
    SFT_OP_SKIP_ON_PIN_LEVEL      = 3'h1,
    SFT_OP_SKIP_ON_STANDBY_FLAG   = 3'h2,
    SFT_OP_SKIP_ON_TIMER_ONE_FLAG = 3'h3,
    SFT_OP_SKIP_ON_TIMER_TWO_FLAG = 3'h4
  } sft_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    SFT_ST_RUN      = 2'h1,
    SFT_ST_SUPPRESS = 2'h2
  } sft_state_t;

  typedef struct packed {
    logic    valid;
    sft_op_t op;
  } sft_instr_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sft_apb_in_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sft_apb_out_t;

endpackage

// file: rtl/sft_pin_sync.sv
// Three-stage synchroniser for the external interrupt pin.
module sft_pin_sync
  import sft_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic pin_async,
  output logic      level_q
);

  logic [2:0] stage_q;

  // Shift chain; stage 0 is read only by stage 1
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= SFT_SYNC_RST;
    end else begin
      stage_q <= {stage_q[1:0], pin_async};
    end
  end

  // Level moves only once second and third stage agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= SFT_PIN_RST;
    end else if (stage_q[2] == stage_q[1]) begin
      level_q <= stage_q[2];
    end
  end

endmodule

// file: rtl/sft_req_flag.sv
// Sticky request flag: hardware sets, skip logic clears, set wins.
module sft_req_flag
  import sft_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag_q
);

  // Set beats clear so a request in the clearing cycle survives
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= SFT_FLAG_RST;
    end else if (set) begin
      flag_q <= 1'h1;
    end else if (clear) begin
      flag_q <= 1'h0;
    end
  end

endmodule

// file: rtl/sft_skip_unit.sv
// Skip-on-flag test unit with APB control registers and interrupt.
//
// The register addresses and the APB register port were left to the implementer.
module sft_skip_unit
  import sft_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire sft_apb_in_t  apb_in,
  output sft_apb_out_t      apb_out_q,
  input  wire sft_instr_t   instr,
  input  wire logic         ext_int_pin,
  input  wire logic         standby_flag,
  input  wire logic         timer_one_set,
  input  wire logic         timer_two_set,
  output logic              skip_taken_q,
  output logic              suppress_q,
  output logic              done_q,
  output logic              timer_one_request_flag_q,
  output logic              timer_two_request_flag_q,
  output logic              irq_q
);

  // Control and status state
  sft_state_t  state_q;
  sft_state_t  state_d;
  logic [3:0]  pin_irq_control_reg_q;
  logic [3:0]  irq_enable_control_reg_q;
  logic [3:0]  int_status_q;
  logic [3:0]  int_status_d;
  logic [3:0]  int_mask_q;
  logic [3:0]  status_rd_q;
  logic        pin_level;
  logic        pin_level_prev_q;
  logic        pin_polarity_select_bit;
  logic        timer_one_irq_enable_bit;
  logic        timer_two_irq_enable_bit;
  logic        exec;
  logic        is_test_op;
  logic        cond;
  logic        skip_d;
  logic        t1_clear;
  logic        t2_clear;
  logic [3:0]  events;

  // APB decode
  logic        apb_setup;
  logic        apb_access;
  logic        apb_hit;
  logic        apb_wr;
  logic        apb_rd;
  logic [31:0] rd_mux;

  assign pin_polarity_select_bit  = pin_irq_control_reg_q[SFT_PIN_POL_BIT];
  assign timer_one_irq_enable_bit = irq_enable_control_reg_q[SFT_T1_EN_BIT];
  assign timer_two_irq_enable_bit = irq_enable_control_reg_q[SFT_T2_EN_BIT];

  // Pin crosses in through three stages
  sft_pin_sync u_pin_sync (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .pin_async (ext_int_pin),
    .level_q   (pin_level)
  );

  // Timer request flags, set by the timer, cleared by a skip
  sft_req_flag u_timer_one_flag (
    .mclk    (mclk),
    .reset_n (reset_n),
    .set     (timer_one_set),
    .clear   (t1_clear),
    .flag_q  (timer_one_request_flag_q)
  );

  sft_req_flag u_timer_two_flag (
    .mclk    (mclk),
    .reset_n (reset_n),
    .set     (timer_two_set),
    .clear   (t2_clear),
    .flag_q  (timer_two_request_flag_q)
  );

  // A word issued while suppressed must not act, even if it is a test
  assign exec = instr.valid && (state_q == SFT_ST_RUN);

  // Skip condition of each test
  always_comb begin
    cond       = 1'h0;
    is_test_op = 1'h1;
    case (instr.op)
      SFT_OP_SKIP_ON_PIN_LEVEL: begin
        cond = (pin_level == pin_polarity_select_bit);
      end
      SFT_OP_SKIP_ON_STANDBY_FLAG: begin
        cond = standby_flag;
      end
      SFT_OP_SKIP_ON_TIMER_ONE_FLAG: begin
        cond = !timer_one_irq_enable_bit && timer_one_request_flag_q;
      end
      SFT_OP_SKIP_ON_TIMER_TWO_FLAG: begin
        cond = !timer_two_irq_enable_bit && timer_two_request_flag_q;
      end
      default: begin
        is_test_op = 1'h0;
      end
    endcase
  end

  assign skip_d = exec && is_test_op && cond;

  // Clears only on a real skip; a no-op test leaves the flag alone
  assign t1_clear = skip_d && (instr.op == SFT_OP_SKIP_ON_TIMER_ONE_FLAG);
  assign t2_clear = skip_d && (instr.op == SFT_OP_SKIP_ON_TIMER_TWO_FLAG);

  // Standby flag is an input only: nothing here can write it

  // Sequencer: after a skip, the next issued word is swallowed
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFT_ST_RUN: begin
        if (skip_d) begin
          state_d = SFT_ST_SUPPRESS;
        end
      end
      SFT_ST_SUPPRESS: begin
        if (instr.valid) begin
          state_d = SFT_ST_RUN;
        end
      end
      default: begin
        state_d = SFT_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SFT_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Suppress is the state bit itself, so it stays a flop output
  assign suppress_q = state_q[1];

  // One-cycle completion; done and skip flags are registered outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_q       <= 1'h0;
      skip_taken_q <= 1'h0;
    end else begin
      done_q       <= exec && is_test_op;
      skip_taken_q <= skip_d;
    end
  end

  // Pin edge detect on the synchronised level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_level_prev_q <= SFT_PIN_RST;
    end else begin
      pin_level_prev_q <= pin_level;
    end
  end

  // Event vector placed by the field constants so the map has one source
  always_comb begin
    events                  = 4'h0;
    events[SFT_EV_SKIP]     = skip_d;
    events[SFT_EV_T1_SET]   = timer_one_set;
    events[SFT_EV_T2_SET]   = timer_two_set;
    events[SFT_EV_PIN_EDGE] = (pin_level != pin_level_prev_q);
  end

  // APB phases; pready answers in the first access cycle
  assign apb_setup  = apb_in.psel && !apb_in.penable;
  assign apb_access = apb_in.psel && apb_in.penable && apb_out_q.pready;
  assign apb_wr     = apb_access && apb_in.pwrite && apb_hit;
  assign apb_rd     = apb_access && !apb_in.pwrite && apb_hit;

  always_comb begin
    apb_hit = 1'h1;
    rd_mux  = 32'h0000_0000;
    case (apb_in.paddr)
      SFT_OFS_PIN_CTRL: begin
        rd_mux[3:0] = pin_irq_control_reg_q;
      end
      SFT_OFS_IRQ_EN: begin
        rd_mux[3:0] = irq_enable_control_reg_q;
      end
      SFT_OFS_FLAGS: begin
        rd_mux[4:0] = {suppress_q, pin_level, standby_flag,
                       timer_two_request_flag_q, timer_one_request_flag_q};
      end
      SFT_OFS_INT_STATUS: begin
        rd_mux[3:0] = int_status_q;
      end
      SFT_OFS_INT_MASK: begin
        rd_mux[3:0] = int_mask_q;
      end
      default: begin
        apb_hit = 1'h0;
      end
    endcase
  end

  // Read data and error are captured in setup, held through access
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      apb_out_q <= '0;
    end else begin
      apb_out_q.pready  <= apb_setup;
      apb_out_q.pslverr <= apb_setup && !apb_hit;
      if (apb_setup) begin
        apb_out_q.prdata <= apb_in.pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Status bits actually shown to the reader; only those get cleared
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_rd_q <= SFT_STATUS_RST;
    end else if (apb_setup) begin
      status_rd_q <= (apb_in.paddr == SFT_OFS_INT_STATUS) ? int_status_q : 4'h0;
    end
  end

  // Control registers written at the access edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_irq_control_reg_q    <= SFT_PIN_CTRL_RST;
      irq_enable_control_reg_q <= SFT_IRQ_EN_RST;
      int_mask_q               <= SFT_MASK_RST;
    end else if (apb_wr) begin
      case (apb_in.paddr)
        SFT_OFS_PIN_CTRL: begin
          pin_irq_control_reg_q <= apb_in.pwdata[3:0];
        end
        SFT_OFS_IRQ_EN: begin
          irq_enable_control_reg_q <= apb_in.pwdata[3:0];
        end
        SFT_OFS_INT_MASK: begin
          int_mask_q <= apb_in.pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky status; a new event wins over the read clear
  always_comb begin
    int_status_d = int_status_q;
    if (apb_rd && (apb_in.paddr == SFT_OFS_INT_STATUS)) begin
      int_status_d = int_status_d & ~status_rd_q;
    end
    int_status_d = int_status_d | events;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_q <= SFT_STATUS_RST;
    end else begin
      int_status_q <= int_status_d;
    end
  end

  // Level interrupt, one cycle behind status so it stays a flop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= |(int_status_q & int_mask_q);
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_pin_level_skip: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_PIN_LEVEL
    |=> suppress_q == ($past(pin_level) == $past(pin_polarity_select_bit))
  ) else $error("pin level skip wrong");

  chk_standby_skip: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_STANDBY_FLAG
    |=> suppress_q == $past(standby_flag) && skip_taken_q == $past(standby_flag)
  ) else $error("standby skip wrong");

  chk_t1_skip_clear: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_TIMER_ONE_FLAG && !timer_one_irq_enable_bit
    && timer_one_request_flag_q && !timer_one_set
    |=> suppress_q && !timer_one_request_flag_q
  ) else $error("timer one skip did not clear");

  chk_t1_noop: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_TIMER_ONE_FLAG && timer_one_irq_enable_bit
    && timer_one_request_flag_q
    |=> !suppress_q && !skip_taken_q && timer_one_request_flag_q
  ) else $error("timer one no-op changed state");

  chk_t2_skip_clear: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_TIMER_TWO_FLAG && !timer_two_irq_enable_bit
    && timer_two_request_flag_q && !timer_two_set
    |=> suppress_q && !timer_two_request_flag_q
  ) else $error("timer two skip did not clear");

  chk_t2_noop: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_TIMER_TWO_FLAG && timer_two_irq_enable_bit
    && timer_two_request_flag_q
    |=> !suppress_q && !skip_taken_q && timer_two_request_flag_q
  ) else $error("timer two no-op changed state");

  chk_t2_no_skip: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_TIMER_TWO_FLAG && !timer_two_request_flag_q
    |=> !skip_taken_q
  ) else $error("timer two skipped on clear flag");

  chk_one_cycle_done: assert property (
    exec && is_test_op |=> done_q && (skip_taken_q == suppress_q)
  ) else $error("test did not finish in one cycle");

  chk_suppress_next: assert property (
    suppress_q && instr.valid |=> !suppress_q && !done_q && !skip_taken_q
  ) else $error("suppressed word took effect");

  chk_suppress_hold: assert property (
    suppress_q && !instr.valid |=> suppress_q
  ) else $error("suppress dropped without a word");

  chk_apb_answer: assert property (
    apb_setup |=> apb_out_q.pready ##1 !apb_out_q.pready
  ) else $error("apb answer timing wrong");

  chk_t1_no_skip: assert property (
    exec && instr.op == SFT_OP_SKIP_ON_TIMER_ONE_FLAG && !timer_one_request_flag_q
    |=> !skip_taken_q && !suppress_q
  ) else $error("timer one skipped on clear flag");

  chk_skip_status: assert property (
    skip_d |=> int_status_q[SFT_EV_SKIP]
  ) else $error("skip event not recorded");

endmodule

// file: verif/sft_pin_source.sv
// Behavioural source of the external interrupt pin, the block's far side.
module sft_pin_source (
  input  wire logic mclk,
  input  wire logic level,
  input  wire logic slow,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Follows the requested level, promptly or two edges late, always off the edge
  // since the real pin has no relation to the core clock
  initial begin
    pin = 1'b0;
    forever begin
      @(posedge mclk);
      if (level !== pin) begin
        if (slow)
          repeat (2) @(posedge mclk);
        #13 pin = level;
      end
    end
  end
endmodule

// file: verif/tb_skip_on_flag_test_unit.sv
// Self-checking bench for the skip-on-flag test unit against a behavioural model.
module tb_skip_on_flag_test_unit
  import sft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         mclk;
  logic         reset_n;
  sft_apb_in_t  apb_in;
  sft_apb_out_t apb_out_q;
  sft_instr_t   instr;
  logic         ext_int_pin, standby_flag, timer_one_set, timer_two_set;
  logic         skip_taken_q, suppress_q, done_q, irq_q;
  logic         timer_one_request_flag_q, timer_two_request_flag_q;
  logic         pin_level, pin_slow, tm, en, sk, s;
  logic [31:0]  rd;
  logic         err;
  int           n_errors, tests_run, m_t1, m_t2, k;

  sft_skip_unit uut (
    .mclk                     (mclk),
    .reset_n                  (reset_n),
    .apb_in                   (apb_in),
    .apb_out_q                (apb_out_q),
    .instr                    (instr),
    .ext_int_pin              (ext_int_pin),
    .standby_flag             (standby_flag),
    .timer_one_set            (timer_one_set),
    .timer_two_set            (timer_two_set),
    .skip_taken_q             (skip_taken_q),
    .suppress_q               (suppress_q),
    .done_q                   (done_q),
    .timer_one_request_flag_q (timer_one_request_flag_q),
    .timer_two_request_flag_q (timer_two_request_flag_q),
    .irq_q                    (irq_q)
  );

  sft_pin_source pin_src (
    .mclk  (mclk),
    .level (pin_level),
    .slow  (pin_slow),
    .pin   (ext_int_pin)
  );

  // Comparison and closing report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    apb_in.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (apb_out_q.pready === 1'b1)
        break;
    end
    if (i == 20) begin
      n_errors++;
      end_of_test();
    end
    rd = apb_out_q.prdata;
    err = apb_out_q.pslverr;
    apb_in <= '0;
  endtask

  // Issue one instruction word and check the one-cycle answer
  task automatic exec(input sft_op_t op, input logic skp, input logic dn);
    @(posedge mclk);
    instr <= '{valid: 1'b1, op: op};
    @(posedge mclk);
    instr <= '0;
    #1;
    chk("done", dn, done_q);
    chk("skip", skp, skip_taken_q);
    chk("suppress", skp, suppress_q);
  endtask

  // A skip must swallow the next word, here a test that would otherwise skip
  task automatic run(input sft_op_t op, input logic skp, input logic sb);
    exec(op, skp, 1'b1);
    if (skp) begin
      standby_flag <= 1'b1;
      exec(SFT_OP_SKIP_ON_STANDBY_FLAG, 1'b0, 1'b0);
    end
    standby_flag <= sb;
  endtask

  // Waits until the synchronised pin level shows in the flags register
  task automatic wait_pin(input logic lvl);
    int i;
    for (i = 0; i < 20; i++) begin
      apb(1'b0, SFT_OFS_FLAGS, 32'h0);
      if (rd[3] === lvl)
        break;
    end
    if (i == 20) begin
      n_errors++;
      end_of_test();
    end
  endtask

  // Free-running core clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    apb_in = '0;
    instr = '0;
    {standby_flag, timer_one_set, timer_two_set, pin_level, pin_slow} = 5'h00;
    n_errors = 0;
    tests_run = 0;
    m_t1 = 0;
    m_t2 = 0;
    void'($urandom(94));
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values of every register, then an unmapped word
    for (k = 0; k < 6; k++) begin
      apb(1'b0, 32'(k * 4), 32'h0);
      chk("reset read", 32'h0, rd);
      chk("slave error", (k == 5), 32'(err));
    end
    // Pin test for both polarities and both levels
    for (k = 0; k < 4; k++) begin
      pin_level <= k[0];
      pin_slow <= 1'($urandom % 2);
      wait_pin(k[0]);
      apb(1'b1, SFT_OFS_PIN_CTRL, ($urandom & 32'hFFFF_FFFB) | {29'h0, k[1], 2'h0});
      run(SFT_OP_SKIP_ON_PIN_LEVEL, k[0] == k[1], 1'b0);
    end
    // Standby test with random flag values
    for (k = 0; k < 6; k++) begin
      s = 1'($urandom % 2);
      standby_flag <= s;
      run(SFT_OP_SKIP_ON_STANDBY_FLAG, s, s);
      apb(1'b0, SFT_OFS_FLAGS, 32'h0);
      chk("standby", s, rd[2]);
    end
    // Timer tests: every enable setting, with and without a pending request
    for (k = 0; k < 8; k++) begin
      {tm, en} = k[2:1];
      apb(1'b1, SFT_OFS_IRQ_EN, {28'h0, en & tm, en & ~tm, 2'h0});
      if (k[0]) begin
        @(posedge mclk);
        timer_one_set <= ~tm;
        timer_two_set <= tm;
        @(posedge mclk);
        {timer_one_set, timer_two_set} <= 2'h0;
        if (tm)
          m_t2 = 1;
        else
          m_t1 = 1;
      end
      sk = !en && (tm ? m_t2 : m_t1);
      run(tm ? SFT_OP_SKIP_ON_TIMER_TWO_FLAG : SFT_OP_SKIP_ON_TIMER_ONE_FLAG, sk, 1'b0);
      if (sk && tm)
        m_t2 = 0;
      else if (sk)
        m_t1 = 0;
      chk("t1 flag", m_t1, timer_one_request_flag_q);
      chk("t2 flag", m_t2, timer_two_request_flag_q);
    end
    // Other words do nothing; then clear every event seen so far
    exec(SFT_OP_OTHER, 1'b0, 1'b0);
    apb(1'b0, SFT_OFS_INT_STATUS, 32'h0);
    chk("status all", 32'hF, rd);
    // Skip event interrupt: masked, unmasked, then cleared by reading status
    apb(1'b1, SFT_OFS_INT_MASK, 32'h0);
    standby_flag <= 1'b1;
    run(SFT_OP_SKIP_ON_STANDBY_FLAG, 1'b1, 1'b0);
    repeat (3) @(posedge mclk);
    chk("irq masked", 32'h0, irq_q);
    apb(1'b1, SFT_OFS_INT_MASK, 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h1, irq_q);
    apb(1'b0, SFT_OFS_INT_STATUS, 32'h0);
    chk("status skip", 32'h1, rd[0]);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 32'h0, irq_q);
    apb(1'b0, SFT_OFS_INT_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    end_of_test();
  end
endmodule
